// *** hw/walker_pkg.sv ***
// Purpose: Shared constants for the media walker and root header builder
// Assumes: 100 MHz ref_clk, Avalon-MM register access
// Notes:   Offsets are word indices times four
package walker_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [5:0] OFS_CTRL     = 6'h00;
    localparam logic [5:0] OFS_STATUS   = 6'h04;
    localparam logic [5:0] OFS_DW6      = 6'h08;
    localparam logic [5:0] OFS_DW7      = 6'h0C;
    localparam logic [5:0] OFS_DW8      = 6'h10;
    localparam logic [5:0] OFS_DW9      = 6'h14;
    localparam logic [5:0] OFS_DW10     = 6'h18;
    localparam logic [5:0] OFS_DW11     = 6'h1C;
    localparam logic [5:0] OFS_DW12     = 6'h20;
    localparam logic [5:0] OFS_DW13     = 6'h24;
    localparam logic [5:0] OFS_DW14     = 6'h28;
    localparam logic [5:0] OFS_DW15     = 6'h2C;
    localparam logic [5:0] OFS_DW16     = 6'h30;
    localparam logic [5:0] OFS_HDR_A    = 6'h34;
    localparam logic [5:0] OFS_HDR_B    = 6'h38;
    localparam logic [5:0] OFS_HDR_C    = 6'h3C;
    // ==========================================================
    // Field positions
    localparam int REPEL_BIT    = 30;
    localparam int DUAL_BIT     = 31;
    localparam int COLOR_LSB    = 24;
    localparam int MID_LSB      = 16;
    localparam int MIDY_LSB     = 12;
    localparam int MIDX_LSB     = 8;
    localparam int HI_LSB       = 16;
    localparam int SCR_PTR_LSB  = 10;
    localparam int PTR_LSB      = 5;
    localparam int BAR_SEL_LSB  = 24;
    localparam int BAR_OFS_LSB  = 16;
    localparam int IDO_LSB      = 4;
    localparam int MASK_LSB     = 24;
    localparam int CTRL_START   = 0;
    localparam int CTRL_PERSIST = 1;
    localparam int CTRL_RESTART = 2;
    localparam int CTRL_CONST   = 3;
    localparam int CTRL_SCR_EN  = 4;
    localparam int CTRL_SYNC    = 5;
    localparam logic [3:0] SCR_SIZE_MAX = 4'hB;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // ==========================================================
    // Payload register kinds
    localparam logic [1:0] KIND_HEADER = 2'h0;
    localparam logic [1:0] KIND_CONST  = 2'h1;
    localparam logic [1:0] KIND_SPAWN  = 2'h2;
    localparam logic [1:0] KIND_INLINE = 2'h3;
endpackage : walker_pkg

// *** hw/media_walker_root_payload.sv ***
// Purpose: Media walker position generator and root header builder
// Assumes: Software loads walker words and header fields, then starts
// Notes:   One payload dword per accepted beat, eight beats per register
//
// Contract
// [RULE1] Software avoids repel with dual mode
// [RULE2] Inner loop repeats colour count plus one
// [RULE3] Middle loop extra steps and unit steps
// [RULE4] Global and local loop exec counts
// [RULE5] Local loop bounded by block resolutions
// [RULE6] Local loop start and end coordinates
// [RULE7] Local outer strides signed nine bits
// [RULE8] Local inner strides signed nine bits
// [RULE9] Global loop bounded by global resolutions
// [RULE10] Global loop starts at signed locations
// [RULE11] Global outer and inner signed strides
// [RULE12] Constants precede spawn data, then payload
// [RULE13] Scratch pointer kilobyte aligned when enabled
// [RULE14] Header carries eight bit thread tag
// [RULE15] Binding and sampler pointers 32-byte aligned
// [RULE16] Scratch size code limited to eleven
// [RULE17] Barrier select and offset, top bit zero
// [RULE18] Header carries descriptor offset
// [RULE19] Header reports scoreboard Y, X, colour
// [RULE20] Dependency mask ANDed, bit 24 first
// [RULE21] Lowest dword carries return buffer handle
// [RULE22] Persistent payload header, constants, inline
// [RULE23] Restart flag in pointer dword bit 0; code puts it in header dword 2 bit 0, in place of colour bit 0
// [RULE24] Valid ready output, held until accepted
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module media_walker_root_payload (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [1:0]  out_kind,
    output logic      [2:0]  out_dword,
    output logic      [31:0] out_data,
    output logic             out_last
);
    // ==========================================================
    // State
    typedef enum {ST_IDLE, ST_HEADER, ST_CONST, ST_SPAWN, ST_INLINE, ST_STEP} phase_type;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] dw6, dw7, dw8, dw9, dw10, dw11, dw12, dw13, dw14, dw15, dw16;
        logic [31:0] hdr_a;   // binding ptr, upper 27 bits
        logic [31:0] hdr_b;   // sampler ptr, scratch size
        logic [31:0] hdr_c;   // barrier, handle, mask, tag
        logic [31:0] rdata;
        logic        ack;
        logic        wreq;
        logic [2:0]  odw;
        logic        vld;
        logic [1:0]  kind;
        logic [2:0]  dwi;
        logic [31:0] data;
        logic        last;
        logic [8:0]  gx, gy, lx, ly, lrow_x, lrow_y, grow_x, grow_y;
        logic [3:0]  color;
        logic [4:0]  mid;
        logic [9:0]  lcnt, gcnt;
        logic [3:0]  creg;
        logic        busy;
        logic [31:0] threads;
        phase_type   ph;
    } state_type;

    state_type cur_r, cur_nxt;

    // ==========================================================
    // Helpers
    function automatic logic [8:0] s9(input logic [9:0] f);
        s9 = f[8:0];
    endfunction : s9

    function automatic logic [8:0] hi9(input logic [31:0] w);
        hi9 = w[walker_pkg::HI_LSB +: 9];
    endfunction : hi9

    logic [8:0]  px, py;
    logic        inner_end, outer_end;
    logic [31:0] hdr_word;

    always_comb begin
        px = cur_r.gx + cur_r.lx;
        py = cur_r.gy + cur_r.ly;
        inner_end = (cur_r.lx >= cur_r.dw10[8:0]) || (cur_r.lx >= cur_r.dw8[8:0]); // [RULE5] [RULE6]
        outer_end = (cur_r.ly >= hi9(cur_r.dw10)) || (cur_r.ly >= hi9(cur_r.dw8));
        case (cur_r.dwi)
            3'h0: hdr_word = {cur_r.hdr_c[7:0] & cur_r.dw6[7:0], 8'h00,
                              cur_r.hdr_c[31:16]}; // [RULE20] [RULE21]
            3'h1: hdr_word = {7'h00, py, 7'h00, px}; // [RULE19]
            3'h2: hdr_word = {4'h0, cur_r.hdr_c[11:8], 1'b0, cur_r.hdr_b[10:4],
                              7'h00, cur_r.hdr_b[15:11], cur_r.color[3:1],
                              cur_r.ph == ST_HEADER && cur_r.ctrl[walker_pkg::CTRL_PERSIST]
                              ? cur_r.ctrl[walker_pkg::CTRL_RESTART] : cur_r.color[0]};
                              // [RULE17] [RULE18] [RULE23]
            3'h3: hdr_word = {cur_r.hdr_b[31:walker_pkg::PTR_LSB], 1'b0,
                              (cur_r.hdr_b[3:0] > walker_pkg::SCR_SIZE_MAX)
                              ? walker_pkg::SCR_SIZE_MAX : cur_r.hdr_b[3:0]}; // [RULE15] [RULE16]
            3'h4: hdr_word = {cur_r.hdr_a[31:walker_pkg::PTR_LSB], 5'h00}; // [RULE15]
            3'h5: hdr_word = {cur_r.ctrl[walker_pkg::CTRL_SCR_EN]
                              ? cur_r.dw16[31:walker_pkg::SCR_PTR_LSB] : 22'h0,
                              2'b00, cur_r.hdr_c[7:0]}; // [RULE13] [RULE14]
            default: hdr_word = walker_pkg::RESET_WORD;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.ack = 1'b0;
        cur_nxt.wreq = 1'b1;
        if ((avs_read || avs_write) && !cur_r.ack) begin
            cur_nxt.ack = 1'b1;
            cur_nxt.wreq = 1'b0;
            cur_nxt.rdata = walker_pkg::RESET_WORD;
            if (avs_write && !cur_r.busy) begin
                case (avs_address)
                    walker_pkg::OFS_CTRL:  cur_nxt.ctrl  = avs_writedata;
                    walker_pkg::OFS_DW6:   cur_nxt.dw6   = avs_writedata;
                    walker_pkg::OFS_DW7:   cur_nxt.dw7   = avs_writedata;
                    walker_pkg::OFS_DW8:   cur_nxt.dw8   = avs_writedata;
                    walker_pkg::OFS_DW9:   cur_nxt.dw9   = avs_writedata;
                    walker_pkg::OFS_DW10:  cur_nxt.dw10  = avs_writedata;
                    walker_pkg::OFS_DW11:  cur_nxt.dw11  = avs_writedata;
                    walker_pkg::OFS_DW12:  cur_nxt.dw12  = avs_writedata;
                    walker_pkg::OFS_DW13:  cur_nxt.dw13  = avs_writedata;
                    walker_pkg::OFS_DW14:  cur_nxt.dw14  = avs_writedata;
                    walker_pkg::OFS_DW15:  cur_nxt.dw15  = avs_writedata;
                    walker_pkg::OFS_DW16:  cur_nxt.dw16  = avs_writedata;
                    walker_pkg::OFS_HDR_A: cur_nxt.hdr_a = avs_writedata;
                    walker_pkg::OFS_HDR_B: cur_nxt.hdr_b = avs_writedata;
                    walker_pkg::OFS_HDR_C: cur_nxt.hdr_c = avs_writedata;
                    default: ;
                endcase
            end
            if (avs_read) begin
                case (avs_address)
                    walker_pkg::OFS_CTRL:   cur_nxt.rdata = cur_r.ctrl;
                    walker_pkg::OFS_STATUS: cur_nxt.rdata = {cur_r.threads[30:0], cur_r.busy};
                    walker_pkg::OFS_DW6:    cur_nxt.rdata = cur_r.dw6;
                    walker_pkg::OFS_DW7:    cur_nxt.rdata = cur_r.dw7;
                    walker_pkg::OFS_HDR_A:  cur_nxt.rdata = cur_r.hdr_a;
                    walker_pkg::OFS_HDR_B:  cur_nxt.rdata = cur_r.hdr_b;
                    walker_pkg::OFS_HDR_C:  cur_nxt.rdata = cur_r.hdr_c;
                    default: cur_nxt.rdata = walker_pkg::RESET_WORD;
                endcase
            end
        end

        if (cur_r.vld && out_ready) begin
            cur_nxt.vld = 1'b0; // [RULE24]
        end

        case (cur_r.ph)
            ST_IDLE: begin
                if (cur_r.ctrl[walker_pkg::CTRL_START] && !cur_r.ack) begin
                    cur_nxt.ctrl[walker_pkg::CTRL_START] = 1'b0;
                    cur_nxt.busy = 1'b1;
                    cur_nxt.threads = walker_pkg::RESET_WORD;
                    cur_nxt.gx = s9(cur_r.dw14[9:0]); // [RULE10]
                    cur_nxt.gy = s9(cur_r.dw14[25:16]);
                    cur_nxt.grow_x = s9(cur_r.dw14[9:0]);
                    cur_nxt.grow_y = s9(cur_r.dw14[25:16]);
                    cur_nxt.lx = cur_r.dw9[8:0]; // [RULE6]
                    cur_nxt.ly = hi9(cur_r.dw9);
                    cur_nxt.lrow_x = cur_r.dw9[8:0];
                    cur_nxt.lrow_y = hi9(cur_r.dw9);
                    cur_nxt.color = 4'h0;
                    cur_nxt.mid = 5'h00;
                    cur_nxt.lcnt = 10'h000;
                    cur_nxt.gcnt = 10'h000;
                    cur_nxt.dwi = 3'h0;
                    cur_nxt.ph = ST_HEADER;
                end
            end
            ST_HEADER, ST_CONST, ST_SPAWN, ST_INLINE: begin
                if (!cur_r.vld || out_ready) begin
                    cur_nxt.vld = 1'b1; // [RULE24]
                    cur_nxt.kind = (cur_r.ph == ST_HEADER) ? walker_pkg::KIND_HEADER :
                                   (cur_r.ph == ST_CONST)  ? walker_pkg::KIND_CONST :
                                   (cur_r.ph == ST_SPAWN)  ? walker_pkg::KIND_SPAWN :
                                                             walker_pkg::KIND_INLINE;
                    cur_nxt.data = (cur_r.ph == ST_HEADER) ? hdr_word : cur_r.dw7;
                    cur_nxt.last = 1'b0;
                    cur_nxt.odw = cur_r.dwi;
                    cur_nxt.dwi = cur_r.dwi + 3'h1;
                    if (cur_r.dwi == 3'h7) begin
                        cur_nxt.dwi = 3'h0;
                        // Header, constants, spawn data, then inline
                        if (cur_r.ph == ST_HEADER && cur_r.ctrl[walker_pkg::CTRL_CONST]) begin
                            cur_nxt.ph = ST_CONST; // [RULE12] [RULE22]
                        end else if (cur_r.ph != ST_SPAWN && cur_r.ph != ST_INLINE
                                     && cur_r.ctrl[walker_pkg::CTRL_SYNC]
                                     && !cur_r.ctrl[walker_pkg::CTRL_PERSIST]) begin
                            cur_nxt.ph = ST_SPAWN; // [RULE12]
                        end else if (cur_r.ph != ST_INLINE) begin
                            cur_nxt.ph = ST_INLINE; // [RULE22]
                        end else begin
                            cur_nxt.last = 1'b1;
                            cur_nxt.ph = ST_STEP;
                        end
                    end
                end
            end
            ST_STEP: begin
                cur_nxt.threads = cur_r.threads + 32'h1;
                cur_nxt.ph = ST_HEADER;
                if (cur_r.color != cur_r.dw6[27:24]) begin
                    cur_nxt.color = cur_r.color + 4'h1; // [RULE2]
                end else begin
                    cur_nxt.color = 4'h0;
                    if (cur_r.mid != cur_r.dw6[20:16]) begin
                        cur_nxt.mid = cur_r.mid + 5'h01; // [RULE3]
                        cur_nxt.lx = cur_r.lx + {{8{cur_r.dw6[9]}}, cur_r.dw6[8]};
                        cur_nxt.ly = cur_r.ly + {{8{cur_r.dw6[13]}}, cur_r.dw6[12]};
                    end else if (!inner_end) begin
                        cur_nxt.mid = 5'h00;
                        cur_nxt.lx = cur_r.lx + s9(cur_r.dw12[9:0]); // [RULE8]
                        cur_nxt.ly = cur_r.ly + s9(cur_r.dw12[25:16]);
                    end else if (!outer_end
                                 && cur_r.lcnt != cur_r.dw7[9:0]) begin // [RULE4]
                        cur_nxt.mid = 5'h00;
                        cur_nxt.lcnt = cur_r.lcnt + 10'h001;
                        cur_nxt.lrow_x = cur_r.lrow_x + s9(cur_r.dw11[9:0]); // [RULE7]
                        cur_nxt.lrow_y = cur_r.lrow_y + s9(cur_r.dw11[25:16]);
                        cur_nxt.lx = cur_r.lrow_x + s9(cur_r.dw11[9:0]);
                        cur_nxt.ly = cur_r.lrow_y + s9(cur_r.dw11[25:16]);
                    end else if (cur_r.gcnt != cur_r.dw7[25:16]) begin // [RULE4]
                        cur_nxt.mid = 5'h00;
                        cur_nxt.lcnt = 10'h000;
                        cur_nxt.gcnt = cur_r.gcnt + 10'h001;
                        cur_nxt.lx = cur_r.dw9[8:0];
                        cur_nxt.ly = hi9(cur_r.dw9);
                        cur_nxt.lrow_x = cur_r.dw9[8:0];
                        cur_nxt.lrow_y = hi9(cur_r.dw9);
                        if ((cur_r.gx + s9(cur_r.dw16[9:0])) < cur_r.dw13[8:0]) begin // [RULE9]
                            cur_nxt.gx = cur_r.gx + s9(cur_r.dw16[9:0]); // [RULE11]
                            cur_nxt.gy = cur_r.gy + s9(cur_r.dw16[25:16]);
                        end else begin
                            cur_nxt.grow_x = cur_r.grow_x + s9(cur_r.dw15[9:0]); // [RULE11]
                            cur_nxt.grow_y = cur_r.grow_y + s9(cur_r.dw15[25:16]);
                            cur_nxt.gx = cur_r.grow_x + s9(cur_r.dw15[9:0]);
                            cur_nxt.gy = cur_r.grow_y + s9(cur_r.dw15[25:16]);
                            if ((cur_r.grow_y + s9(cur_r.dw15[25:16])) >= hi9(cur_r.dw13)) begin
                                cur_nxt.busy = 1'b0; // [RULE9]
                                cur_nxt.ph = ST_IDLE;
                            end
                        end
                    end else begin
                        cur_nxt.busy = 1'b0;
                        cur_nxt.ph = ST_IDLE;
                    end
                end
            end
            default: cur_nxt.ph = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_r      <= '0;
            cur_r.wreq <= 1'b1;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign avs_readdata    = cur_r.rdata;
    assign avs_waitrequest = cur_r.wreq;
    assign out_valid       = cur_r.vld;
    assign out_kind        = cur_r.kind;
    assign out_dword       = cur_r.odw;
    assign out_data        = cur_r.data;
    assign out_last        = cur_r.last;
endmodule : media_walker_root_payload
`default_nettype wire

// *** verification/walker_payload_chk.sv ***
// Purpose: Assertions on the payload stream of the walker block
// Assumes: Bound to media_walker_root_payload
// Notes:   Header fields found by beat dword index
`timescale 1ns/10ps
`default_nettype none
module walker_payload_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [1:0]  out_kind,
    input wire logic [2:0]  out_dword,
    input wire logic [31:0] out_data,
    input wire logic        out_last
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic       new_thr_r;
    logic [1:0] kind_r;
    wire        hv = out_valid && out_kind == walker_pkg::KIND_HEADER;
    // ==========================================================
    // Kind of last accepted beat
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            new_thr_r <= 1'b1;
            kind_r    <= 2'h0;
        end else if (out_valid && out_ready) begin
            new_thr_r <= out_last;
            kind_r    <= out_kind;
        end
    end
    hold_valid_a: assert property (out_valid && !out_ready |=> out_valid)
        else $error("valid dropped before accept");
    hold_beat_a: assert property (out_valid && !out_ready |=> $stable(out_data)
        && $stable(out_kind) && $stable(out_dword) && $stable(out_last))
        else $error("beat changed before accept");
    kind_order_a: assert property (out_valid && !new_thr_r |-> out_kind >= kind_r)
        else $error("payload kinds out of order");
    first_hdr_a: assert property (out_valid && new_thr_r |-> !out_kind)
        else $error("thread does not open with header");
    last_inline_a: assert property (out_valid && out_last |-> &out_kind)
        else $error("thread does not end with inline data");
    bind_ptr_a: assert property (hv && out_dword == 3'h4 |-> out_data[4:0] == 5'h00)
        else $error("binding pointer not aligned");
    scr_size_a: assert property (hv && out_dword == 3'h3 |->
        out_data[3:0] <= walker_pkg::SCR_SIZE_MAX && !out_data[4])
        else $error("scratch size out of range");
    barrier_ofs_a: assert property (hv && out_dword == 3'h2 |->
        !out_data[23] && out_data[31:28] == 4'h0)
        else $error("barrier offset top bit set");
    scratch_ptr_a: assert property (hv && out_dword == 3'h5 |-> out_data[9:8] == 2'h0)
        else $error("scratch pointer reserved bits set");
    cover property (out_valid && out_kind == walker_pkg::KIND_CONST);
    cover property (out_valid && out_kind == walker_pkg::KIND_SPAWN);
    cover property (hv && out_dword == 3'h2 && out_data[0]);
endmodule : walker_payload_chk
bind media_walker_root_payload walker_payload_chk chk (.ref_clk(ref_clk), .rst(rst),
    .out_valid(out_valid), .out_ready(out_ready), .out_kind(out_kind),
    .out_dword(out_dword), .out_data(out_data), .out_last(out_last));
`default_nettype wire

// *** verification/dispatch_sink.sv ***
// Purpose: Thread dispatcher model taking payload beats
// Assumes: One beat per accepting edge
// Notes:   Keeps header dwords and beat counts per thread
`timescale 1ns/10ps
`default_nettype none
module dispatch_sink (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        slow,
    input wire logic        out_valid,
    input wire logic [1:0]  out_kind,
    input wire logic [2:0]  out_dword,
    input wire logic [31:0] out_data,
    input wire logic        out_last,
    output logic            out_ready
);
    logic [31:0] hdr [16][8];
    int          kcnt [16][4];
    int          thr;
    logic [1:0]  tick_r;
    // Accept beats, stalling three of four cycles when slow
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_ready <= 1'b0;
            tick_r    <= 2'h0;
            thr       <= 0;
        end else begin
            tick_r    <= tick_r + 2'h1;
            out_ready <= !slow || tick_r == 2'h2;
            if (out_valid && out_ready) begin
                if (out_kind == walker_pkg::KIND_HEADER) hdr[thr[3:0]][out_dword] <= out_data;
                kcnt[thr[3:0]][out_kind] <= kcnt[thr[3:0]][out_kind] + 1;
                if (out_last) thr <= thr + 1;
            end
        end
    end
endmodule : dispatch_sink
`default_nettype wire

// *** verification/media_walker_root_payload_tb.sv ***
// Purpose: Register driven tests of walker threads and headers
// Assumes: Avalon-MM master tasks, dispatcher model at the stream
// Notes:   Expected header values built from the written fields
`timescale 1ns/10ps
`default_nettype none
module media_walker_root_payload_tb;
    logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest, slow;
    logic        out_valid, out_ready, out_last;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, out_data;
    logic [1:0]  out_kind;
    logic [2:0]  out_dword;
    int          error_cnt, tests_run, t;
    localparam logic [31:0] CFG [11] = '{32'h0100_00FF, 32'h0, 32'h0001_0001,
        32'h0005_0003, 32'h0005_0003, 32'h0, 32'h0000_0001, 32'h0001_0001, 32'h0, 32'h0, 32'h0};
    media_walker_root_payload dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .out_valid(out_valid), .out_ready(out_ready), .out_kind(out_kind),
        .out_dword(out_dword), .out_data(out_data), .out_last(out_last));
    dispatch_sink sink (.ref_clk(ref_clk), .rst(rst), .slow(slow), .out_valid(out_valid),
        .out_kind(out_kind), .out_dword(out_dword), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready));
    // ==========================================================
    // Tasks
    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic hang;
        error_cnt++;
        $display("[ERR] %0t wait ran out", $time);
        print_verdict;
    endtask : hang
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) hang;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask : rd_chk
    task automatic run(input logic [31:0] c, input logic s);
        logic [31:0] q;
        int n;
        n = 0;
        slow <= s;
        t = sink.thr;
        wr(walker_pkg::OFS_CTRL, c);
        repeat (4) @(posedge ref_clk);
        do begin
            bus(1'b0, walker_pkg::OFS_STATUS, 32'h0, q);
            n++;
        end while ((q[0] !== 1'b0 || out_valid !== 1'b0) && n < 3000);
        if (n >= 3000) hang;
        t = t % 16;
    endtask : run
    // ==========================================================
    // Clock and sequence
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, slow, avs_address, avs_writedata} = '0;
        error_cnt = 0;
        tests_run = 0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(walker_pkg::OFS_CTRL, walker_pkg::RESET_WORD);
        rd_chk(walker_pkg::OFS_STATUS, walker_pkg::RESET_WORD);
        for (int i = 0; i < 11; i++) wr(walker_pkg::OFS_DW6 + 6'(4 * i), CFG[i]);
        rd_chk(walker_pkg::OFS_DW6, 32'h0100_00FF);
        wr(walker_pkg::OFS_HDR_A, 32'hABCD_E1F0);
        wr(walker_pkg::OFS_HDR_B, 32'h1234_A85F);
        wr(walker_pkg::OFS_HDR_C, 32'hBEEF_093C);
        rd_chk(walker_pkg::OFS_HDR_A, 32'hABCD_E1F0);
        run(32'h01, 1'b0);
        check(sink.hdr[t][4], 32'hABCD_E1E0);
        check({sink.hdr[t][3][31:16], sink.hdr[t][3][3:0]}, {16'h1234, 4'hB});
        check(sink.hdr[t][2][31:4], {8'h09, 8'h05, 7'h00, 5'h15});
        check(sink.hdr[t][5][7:0], 8'h3C);
        check(sink.hdr[t][0], 32'h3C00_BEEF);
        check({sink.hdr[t][1][24:16], sink.hdr[t][1][8:0]}, {9'd5, 9'd3});
        check(sink.hdr[t][2][3:0], 4'h0);
        check(sink.hdr[(t + 1) % 16][2][3:0], 4'h1);
        check(sink.kcnt[t][1] + sink.kcnt[t][2] == 0, 1'b1);
        run(32'h2F, 1'b1);
        check(sink.hdr[t][2][0], 1'b1);
        check(sink.kcnt[t][2] == 0 && sink.kcnt[t][1] != 0, 1'b1);
        run(32'h39, 1'b1);
        check(sink.kcnt[t][2] != 0 && sink.kcnt[t][1] != 0, 1'b1);
        print_verdict;
    end
endmodule : media_walker_root_payload_tb
`default_nettype wire
